// file: rtl/modem_codec_register_map.sv
// Indexed register bank of the modem codec, with its link-side access port.
// Assumes an upstream slot decoder on the bit clock that hands over one access
// at a time, and board pins that are asynchronous to both clocks.

`timescale 1ns/1ps
`default_nettype none

// How it works
// - Any write to the capability register returns every register to its default.
// - Capability bits 0,1,3,4 follow line select; bit 3 equals 0, 4 equals 1.
// - After power-on capability reads line 1; with sub-assembly pins low, low twelve bits give x009.
// - Capability bits 15:14 give config code from identity pins and primary detect.
// - Capability bits 12:9 always read zero.
// - Capability bits 8:5 return the four sub-assembly pins in order.
// - Line 1: caller ID and support flags one, handset zero, line 2 zero.
// - Rate register holds writable 16-bit rate in hertz, default 48 kHz.
// - Misc control bit 0 selects line; zero is line 1, the default.
// - Misc status bit 12 writable: zero keeps link on, one puts it asleep.
module modem_codec_register_map #(
  parameter logic [15:0] MAKER_CODE_LOW = 16'h1234,    // Arbitrary value
  parameter logic [15:0] MAKER_CODE_HIGH_REV = 16'h5601 // Arbitrary value
) (
  // System clock and cold reset
  input wire logic clk,
  input wire logic resetn,
  // Link side, on the bit clock
  input wire logic bit_clk,
  input wire logic req_valid,
  input wire modem_regs_pkg::reg_req_s req,
  output logic req_busy,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  // Board pins
  input wire modem_regs_pkg::ident_pins_s pins,
  // Control outputs, system clock
  output logic link_sleep,
  output logic line_selector,
  output logic xtal_powerdown,
  output logic [15:0] sample_rate_value
);

  // ****************************************************************
  // Link-domain reset
  // ****************************************************************
  logic link_rst_meta_reg;
  logic link_rst_n_reg;

  // Assert at once, release on the bit clock so the link logic starts clean
  // A raw release could land near a bit clock edge and split the link flops
  always_ff @(posedge bit_clk or negedge resetn) begin
    if (!resetn) begin
      link_rst_meta_reg <= 1'b0;
      link_rst_n_reg <= 1'b0;
    end else begin
      link_rst_meta_reg <= 1'b1;
      link_rst_n_reg <= link_rst_meta_reg;
    end
  end

  // ****************************************************************
  // Link side: request capture and answer
  // ****************************************************************
  modem_regs_pkg::reg_req_s hold_reg;
  logic req_tgl_reg;
  logic ack_meta_reg;
  logic ack_sync_reg;
  logic ack_seen_reg;
  logic [15:0] rdata_reg;
  logic ack_tgl_reg;

  // Hold the access stable while the system side works on it
  always_ff @(posedge bit_clk or negedge link_rst_n_reg) begin
    if (!link_rst_n_reg) begin
      hold_reg <= '0;
      req_tgl_reg <= 1'b0;
    end else if (req_valid && !req_busy) begin
      hold_reg <= req;
      req_tgl_reg <= ~req_tgl_reg;
    end
  end

  // Answer toggle brought back onto the bit clock
  always_ff @(posedge bit_clk or negedge link_rst_n_reg) begin
    if (!link_rst_n_reg) begin
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
    end else begin
      ack_meta_reg <= ack_tgl_reg;
      ack_sync_reg <= ack_meta_reg;
      ack_seen_reg <= ack_sync_reg;
    end
  end

  // Busy from acceptance until the answer returns; one access in flight only
  always_ff @(posedge bit_clk or negedge link_rst_n_reg) begin
    if (!link_rst_n_reg) begin
      req_busy <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      if (ack_sync_reg != ack_seen_reg) begin
        req_busy <= 1'b0;
        rsp_valid <= 1'b1;
        rsp_rdata <= rdata_reg; // Stable since the toggle; written on the same clk edge
      end else if (req_valid && !req_busy) begin
        req_busy <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // System side: request toggle synchroniser
  // ****************************************************************
  logic req_meta_reg;
  logic req_sync_reg;
  logic req_seen_reg;
  logic exec;

  // Only the toggle crosses; the held access word is read after it has settled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
      req_seen_reg <= 1'b0;
    end else begin
      req_meta_reg <= req_tgl_reg;
      req_sync_reg <= req_meta_reg;
      req_seen_reg <= req_sync_reg;
    end
  end

  // One-cycle execute strobe; hold_reg is settled by now
  assign exec = req_sync_reg != req_seen_reg;

  // ****************************************************************
  // Board pin conditioning
  // ****************************************************************
  localparam int PIN_W = $bits(modem_regs_pkg::ident_pins_s);
  logic [PIN_W-1:0] pin_s1_reg;
  logic [PIN_W-1:0] pin_s2_reg;
  logic [PIN_W-1:0] pin_s3_reg;
  modem_regs_pkg::ident_pins_s pin_reg;

  // Three stages; a change counts only once stages two and three agree
  // Slow strap edges would otherwise let one sample mix old and new levels
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else begin
      pin_s1_reg <= pins;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // Per-bit acceptance, so one noisy pin does not stall the others
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_reg <= '0;
    end else begin
      for (int i = 0; i < PIN_W; i++) begin
        if (pin_s2_reg[i] == pin_s3_reg[i]) begin
          pin_reg[i] <= pin_s3_reg[i];
        end
      end
    end
  end

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  logic wr;
  logic soft_reset;
  logic [15:0] preserve_mask_reg;
  logic [modem_regs_pkg::TIMER_WIDTH-1:0] osc_timer_reg;

  assign wr = exec && hold_reg.write;
  assign soft_reset = wr && (hold_reg.index == modem_regs_pkg::IDX_CAPABILITY);

  // Line 1 sample rate in hertz, full 16 bits writable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sample_rate_value <= modem_regs_pkg::RATE_RESET;
    end else if (soft_reset) begin
      sample_rate_value <= modem_regs_pkg::RATE_RESET;
    end else if (wr && hold_reg.index == modem_regs_pkg::IDX_RATE) begin
      sample_rate_value <= hold_reg.wdata;
    end
  end

  // Link sleep control; other bits of that word are not stored
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link_sleep <= modem_regs_pkg::MISC_STATUS_RESET[modem_regs_pkg::MISC_LINK_SLEEP_BIT];
    end else if (soft_reset) begin
      link_sleep <= modem_regs_pkg::MISC_STATUS_RESET[modem_regs_pkg::MISC_LINK_SLEEP_BIT];
    end else if (wr && hold_reg.index == modem_regs_pkg::IDX_MISC_STATUS) begin
      link_sleep <= hold_reg.wdata[modem_regs_pkg::MISC_LINK_SLEEP_BIT];
    end
  end

  // Line select; line 2 is stored as asked although only line 1 is served
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_selector <= modem_regs_pkg::MISC_CTRL_RESET[modem_regs_pkg::CTRL_LINE_SEL_BIT];
    end else if (soft_reset) begin
      line_selector <= modem_regs_pkg::MISC_CTRL_RESET[modem_regs_pkg::CTRL_LINE_SEL_BIT];
    end else if (wr && hold_reg.index == modem_regs_pkg::IDX_MISC_CTRL) begin
      line_selector <= hold_reg.wdata[modem_regs_pkg::CTRL_LINE_SEL_BIT];
    end
  end

  // Crystal power-down; the busy bit of that word is not stored, so its write drops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      xtal_powerdown <= modem_regs_pkg::MISC_CTRL_RESET[modem_regs_pkg::CTRL_XTAL_PD_BIT];
    end else if (soft_reset) begin
      xtal_powerdown <= modem_regs_pkg::MISC_CTRL_RESET[modem_regs_pkg::CTRL_XTAL_PD_BIT];
    end else if (wr && hold_reg.index == modem_regs_pkg::IDX_MISC_CTRL) begin
      xtal_powerdown <= hold_reg.wdata[modem_regs_pkg::CTRL_XTAL_PD_BIT];
    end
  end

  // Preserve mask is stored only; masking of the cold reset is not done here
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      preserve_mask_reg <= modem_regs_pkg::PRESERVE_MASK_RESET;
    end else if (soft_reset) begin
      preserve_mask_reg <= modem_regs_pkg::PRESERVE_MASK_RESET;
    end else if (wr && hold_reg.index == modem_regs_pkg::IDX_PRESERVE_MASK) begin
      preserve_mask_reg <= hold_reg.wdata;
    end
  end

  // Oscillator switch count, low byte only; held here, never counted down
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_timer_reg <= modem_regs_pkg::OSC_TIMER_RESET;
    end else if (soft_reset) begin
      osc_timer_reg <= modem_regs_pkg::OSC_TIMER_RESET;
    end else if (wr && hold_reg.index == modem_regs_pkg::IDX_OSC_TIMER) begin
      osc_timer_reg <= hold_reg.wdata[modem_regs_pkg::TIMER_WIDTH-1:0];
    end
  end

  // ****************************************************************
  // Capability word
  // ****************************************************************
  logic [1:0] codec_config_code;
  logic [3:0] subassembly_lower;
  logic [3:0] subassembly_upper;
  logic line1_support_flag;
  logic line2_support_flag;
  logic line1_callerid_flag;
  logic line2_callerid_flag;
  logic handset_converter_flag;
  logic [15:0] cap_word;

  // Primary detect forces primary; else the active-low ident pins give the code
  assign codec_config_code = pin_reg.primary_detect_signal ? 2'b00 :
    {~pin_reg.codec_ident_pin_high_n, ~pin_reg.codec_ident_pin_low_n};
  assign subassembly_lower = pin_reg.subassembly_pins;
  assign subassembly_upper = 4'h0;
  assign handset_converter_flag = 1'b0;
  // Flags follow the selected line; caller ID flags mirror support flags
  assign line1_support_flag = ~line_selector;
  assign line2_support_flag = line_selector;
  assign line1_callerid_flag = line1_support_flag;
  assign line2_callerid_flag = line2_support_flag;

  always_comb begin
    cap_word = 16'h0000; // Bit 13 reserved stays zero
    cap_word[modem_regs_pkg::CAP_CONFIG_LSB +: 2] = codec_config_code;
    cap_word[modem_regs_pkg::CAP_SUB_LOWER_LSB + 4 +: 4] = subassembly_upper;
    cap_word[modem_regs_pkg::CAP_SUB_LOWER_LSB +: 4] = subassembly_lower;
    cap_word[modem_regs_pkg::CAP_LINE2_CALLERID_BIT] = line2_callerid_flag;
    cap_word[modem_regs_pkg::CAP_LINE1_CALLERID_BIT] = line1_callerid_flag;
    cap_word[modem_regs_pkg::CAP_HANDSET_BIT] = handset_converter_flag;
    cap_word[modem_regs_pkg::CAP_LINE2_SUPPORT_BIT] = line2_support_flag;
    cap_word[modem_regs_pkg::CAP_LINE1_SUPPORT_BIT] = line1_support_flag;
  end

  // ****************************************************************
  // Read multiplexer and answer toggle
  // ****************************************************************
  logic [15:0] read_word;
  logic [15:0] misc_status_word;
  logic [15:0] misc_ctrl_word;

  // Caller ID status bits are not captured here; the reset pattern stands
  always_comb begin
    misc_status_word = modem_regs_pkg::MISC_STATUS_RESET;
    misc_status_word[modem_regs_pkg::MISC_LINK_SLEEP_BIT] = link_sleep;
    misc_ctrl_word = 16'h0000;
    misc_ctrl_word[modem_regs_pkg::CTRL_LINE_SEL_BIT] = line_selector;
    misc_ctrl_word[modem_regs_pkg::CTRL_XTAL_PD_BIT] = xtal_powerdown;
  end

  // Index decode; anything unlisted reads zero
  always_comb begin
    if (hold_reg.index == modem_regs_pkg::IDX_CAPABILITY) begin
      read_word = cap_word;
    end else if (hold_reg.index == modem_regs_pkg::IDX_RATE) begin
      read_word = sample_rate_value;
    end else if (hold_reg.index == modem_regs_pkg::IDX_MISC_STATUS) begin
      read_word = misc_status_word;
    end else if (hold_reg.index == modem_regs_pkg::IDX_MISC_CTRL) begin
      read_word = misc_ctrl_word;
    end else if (hold_reg.index == modem_regs_pkg::IDX_PRESERVE_MASK) begin
      read_word = preserve_mask_reg;
    end else if (hold_reg.index == modem_regs_pkg::IDX_OSC_TIMER) begin
      read_word = {8'h00, osc_timer_reg};
    end else if (hold_reg.index == modem_regs_pkg::IDX_RESERVED_A) begin
      read_word = modem_regs_pkg::READ_ZERO;
    end else if (hold_reg.index == modem_regs_pkg::IDX_RESERVED_B) begin
      read_word = modem_regs_pkg::RESERVED_B_PATTERN;
    end else if (hold_reg.index == modem_regs_pkg::IDX_MAKER_LOW) begin
      read_word = MAKER_CODE_LOW;
    end else if (hold_reg.index == modem_regs_pkg::IDX_MAKER_HIGH) begin
      read_word = MAKER_CODE_HIGH_REV;
    end else begin
      read_word = modem_regs_pkg::READ_ZERO;
    end
  end

  // Read data latched in the same cycle as the toggle; the link-side synchroniser delay lets it settle.
  // Writes answer with the word as it read before the write.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 16'h0000;
      ack_tgl_reg <= 1'b0;
    end else if (exec) begin
      rdata_reg <= read_word;
      ack_tgl_reg <= ~ack_tgl_reg;
    end
  end

endmodule : modem_codec_register_map

`default_nettype wire

// file: rtl/modem_regs_pkg.sv
// Constants, field layouts and carrier types for the modem codec register bank.
// Assumes a 7-bit register index and 16-bit register words as seen on the link.

package modem_regs_pkg;

  // ****************************************************************
  // Register indexes
  // ****************************************************************
  localparam logic [6:0] IDX_CAPABILITY = 7'h3c;
  localparam logic [6:0] IDX_RATE = 7'h40;
  localparam logic [6:0] IDX_MISC_STATUS = 7'h56;
  localparam logic [6:0] IDX_MISC_CTRL = 7'h66;
  localparam logic [6:0] IDX_PRESERVE_MASK = 7'h68;
  localparam logic [6:0] IDX_OSC_TIMER = 7'h6a;
  localparam logic [6:0] IDX_RESERVED_A = 7'h78;
  localparam logic [6:0] IDX_RESERVED_B = 7'h7a;
  localparam logic [6:0] IDX_MAKER_LOW = 7'h7c;
  localparam logic [6:0] IDX_MAKER_HIGH = 7'h7e;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CAP_CONFIG_LSB = 14;
  localparam int CAP_SUB_LOWER_LSB = 5;
  localparam int CAP_LINE2_CALLERID_BIT = 4;
  localparam int CAP_LINE1_CALLERID_BIT = 3;
  localparam int CAP_HANDSET_BIT = 2;
  localparam int CAP_LINE2_SUPPORT_BIT = 1;
  localparam int CAP_LINE1_SUPPORT_BIT = 0;
  localparam int MISC_LINK_SLEEP_BIT = 12;
  localparam int CTRL_LINE_SEL_BIT = 0;
  localparam int CTRL_XTAL_PD_BIT = 1;
  localparam int TIMER_WIDTH = 8;

  // ****************************************************************
  // Reset values and fixed read patterns
  // ****************************************************************
  localparam logic [15:0] RATE_RESET = 16'hbb80;
  localparam logic [15:0] MISC_STATUS_RESET = 16'h4000;
  localparam logic [15:0] MISC_CTRL_RESET = 16'h0000;
  localparam logic [15:0] PRESERVE_MASK_RESET = 16'h0000;
  localparam logic [7:0] OSC_TIMER_RESET = 8'h40;
  localparam logic [15:0] RESERVED_B_PATTERN = 16'h8000;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  // Register access decoded from the link slots
  typedef struct packed {
    logic write;
    logic [6:0] index;
    logic [15:0] wdata;
  } reg_req_s;

  // Strap and identity pins, raw from the board
  typedef struct packed {
    logic primary_detect_signal;
    logic codec_ident_pin_high_n;
    logic codec_ident_pin_low_n;
    logic [3:0] subassembly_pins;
  } ident_pins_s;

endpackage : modem_regs_pkg

// file: tb/modem_regs_properties.sv
// Concurrent checks on the ports of the modem codec register bank.
// Assumes it is bound to the bank and sees only the bank's own ports.
`timescale 1ns/1ps
`default_nettype none
module modem_regs_properties (
  // Clocks and cold reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic bit_clk,
  // Link side
  input wire logic req_valid,
  input wire modem_regs_pkg::reg_req_s req,
  input wire logic req_busy,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  // Pins and control outputs
  input wire modem_regs_pkg::ident_pins_s pins,
  input wire logic link_sleep,
  input wire logic line_selector,
  input wire logic xtal_powerdown,
  input wire logic [15:0] sample_rate_value
);
  logic [6:0] idx_reg;
  logic wr_reg;
  // Remember the access in flight so the answer word can be judged
  always_ff @(posedge bit_clk or negedge resetn) begin
    if (!resetn) begin
      idx_reg <= 7'h00;
      wr_reg <= 1'b0;
    end else if (req_valid && !req_busy) begin
      idx_reg <= req.index;
      wr_reg <= req.write;
    end
  end
  // ****************************************************************
  // Sequences and properties
  // ****************************************************************
  sequence s_cap_write;
    req_valid && !req_busy && req.write && req.index == modem_regs_pkg::IDX_CAPABILITY;
  endsequence
  sequence s_defaults_answer;
    ##[3:5] (rsp_valid && sample_rate_value == 16'hbb80 && !link_sleep && !line_selector && !xtal_powerdown);
  endsequence
  // Read answers only: a write answers with the word from before it
  property p_read(logic [6:0] ix, logic ok);
    @(posedge bit_clk) disable iff (!resetn) rsp_valid && !wr_reg && idx_reg == ix |-> ok;
  endproperty
  a_cap_reserved_zero: assert property (p_read(7'h3c, rsp_rdata[13:9] == 5'h00 && !rsp_rdata[2]))
    else $error("capability reserved bits not zero");
  a_cap_flag_mirror: assert property (p_read(7'h3c, rsp_rdata[4:3] == rsp_rdata[1:0]))
    else $error("capability flags do not mirror");
  a_cap_line_flags: assert property (p_read(7'h3c, rsp_rdata[1:0] == {line_selector, !line_selector}))
    else $error("capability flags ignore line select");
  a_cap_sub_pins: assert property (p_read(7'h3c, rsp_rdata[8:5] == pins.subassembly_pins))
    else $error("sub-assembly bits differ from pins");
  a_cap_config_code: assert property (p_read(7'h3c, rsp_rdata[15:14] == (pins.primary_detect_signal ? 2'b00 :
    {!pins.codec_ident_pin_high_n, !pins.codec_ident_pin_low_n})))
    else $error("config code wrong");
  a_rate_readback: assert property (p_read(7'h40, rsp_rdata == sample_rate_value))
    else $error("rate read differs from rate output");
  a_misc_readback: assert property (p_read(7'h56, rsp_rdata == {3'b010, link_sleep, 12'h000}))
    else $error("misc status read wrong");
  a_ctrl_readback: assert property (p_read(7'h66, rsp_rdata == {14'h0000, xtal_powerdown, line_selector}))
    else $error("misc control read wrong");
  a_rate_needs_access: assert property (@(posedge clk) disable iff (!resetn)
    $changed(sample_rate_value) |-> req_busy)
    else $error("rate changed without an access");
  a_cap_write_defaults: assert property (@(posedge bit_clk) disable iff (!resetn)
    s_cap_write |-> s_defaults_answer)
    else $error("capability write did not restore defaults");
endmodule : modem_regs_properties
bind modem_codec_register_map modem_regs_properties u_modem_regs_properties (.clk(clk), .resetn(resetn),
  .bit_clk(bit_clk), .req_valid(req_valid), .req(req), .req_busy(req_busy), .rsp_valid(rsp_valid),
  .rsp_rdata(rsp_rdata), .pins(pins), .link_sleep(link_sleep), .line_selector(line_selector),
  .xtal_powerdown(xtal_powerdown), .sample_rate_value(sample_rate_value));
`default_nettype wire

// file: tb/link_host_model.sv
// Host controller model for the link side of the register bank.
// Assumes one access at a time; the caller handles a missing answer.
`timescale 1ns/1ps
`default_nettype none
module link_host_model (
  // Link clock and reset
  output logic bit_clk,
  input wire logic resetn,
  // Request and answer
  output logic req_valid,
  output var modem_regs_pkg::reg_req_s req,
  input wire logic req_busy,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata
);
  // Link clock runs free, phase unrelated to the system clock
  initial begin
    bit_clk = 1'b0;
    req_valid = 1'b0;
    req = '0;
    #7.3;
    forever #24 bit_clk = ~bit_clk;
  end
  // One access: request held until taken, then wait for the answer pulse
  task automatic access(input logic wr, input logic [6:0] idx, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 16'h0000;
    @(posedge bit_clk);
    req_valid <= 1'b1;
    req <= {wr, idx, wd};
    // Hold until an edge finds the bank idle, then scramble the stale data
    n = 0;
    do begin
      @(posedge bit_clk);
      n++;
    end while (req_busy !== 1'b0 && n < 12);
    req_valid <= 1'b0;
    req <= ~{wr, idx, wd};
    for (n = 0; n < 12 && !ok; n++) begin
      @(posedge bit_clk);
      if (rsp_valid === 1'b1) begin
        rd = rsp_rdata;
        ok = 1'b1;
      end
    end
  endtask : access
endmodule : link_host_model
`default_nettype wire

// file: tb/modem_codec_register_map_tb.sv
// Self-checking bench for the modem codec register bank.
// Assumes the host model drives the link and this module drives the pins.
`timescale 1ns/1ps
`default_nettype none
module modem_codec_register_map_tb;
  logic clk, resetn, req_valid, req_busy, rsp_valid, link_sleep, line_selector, xtal_powerdown;
  wire logic bit_clk;
  modem_regs_pkg::reg_req_s req;
  modem_regs_pkg::ident_pins_s pins;
  logic [15:0] rsp_rdata, sample_rate_value, rd;
  int n_errors, num_checks;
  logic prim;
  logic [1:0] idn;
  logic [3:0] sub;
  localparam logic [6:0] IX [10] = '{7'h40, 7'h56, 7'h66, 7'h68, 7'h6a, 7'h78, 7'h7a, 7'h7c, 7'h7e, 7'h20};
  localparam logic [15:0] DV [10] = '{16'hbb80, 16'h4000, 16'h0000, 16'h0000, 16'h0040, 16'h0000,
                                      16'h8000, 16'h1234, 16'h5601, 16'h0000};
  // System clock, 200 MHz
  always #2.5 clk = ~clk;
  modem_codec_register_map u_modem_codec_register_map (.clk(clk), .resetn(resetn), .bit_clk(bit_clk),
    .req_valid(req_valid), .req(req), .req_busy(req_busy), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .pins(pins), .link_sleep(link_sleep), .line_selector(line_selector), .xtal_powerdown(xtal_powerdown),
    .sample_rate_value(sample_rate_value));
  link_host_model u_link_host_model (.bit_clk(bit_clk), .resetn(resetn), .req_valid(req_valid), .req(req),
    .req_busy(req_busy), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic acc(input logic wr, input logic [6:0] idx, input logic [15:0] wd);
    logic ok;
    u_link_host_model.access(wr, idx, wd, rd, ok);
    if (!ok) begin
      n_errors++;
      $display("Error at %0t: no answer from index %h", $time, idx);
      end_of_test();
    end
  endtask : acc
  // Expected capability word for the pins and line held now
  function automatic logic [15:0] cap_exp(input logic line2);
    return {(prim ? 2'b00 : ~idn), 5'h00, sub, line2, !line2, 1'b0, line2, !line2};
  endfunction : cap_exp
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Power-on capability word: line 1, identity from the straps
  task automatic t_power_on;
    {prim, idn, sub} = pins;
    acc(1'b0, 7'h3c, 16'h0000);
    check(rd, cap_exp(1'b0));
    check({4'h0, rd[11:0]}, 16'h0009);
    $display("power-on test done");
  endtask : t_power_on
  // Defaults of every index except capability; scribble first tries writes to read-only places
  task automatic t_defaults(input logic scribble);
    for (int i = 0; i < 10; i++) begin
      if (scribble && (IX[i] >= 7'h78 || IX[i] == 7'h20)) acc(1'b1, IX[i], ~DV[i]);
      acc(1'b0, IX[i], 16'h0000);
      check(rd, DV[i]);
    end
    check(16'({link_sleep, line_selector, xtal_powerdown}), 16'h0000);
    check(sample_rate_value, 16'hbb80);
    $display("defaults test done");
  endtask : t_defaults
  // Every config code and several sub-assembly patterns
  task automatic t_ident;
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      pins <= {k == 0, 2'(k), 4'(k * 3 + 5)};
      repeat (10) @(posedge clk);
      {prim, idn, sub} = pins;
      acc(1'b0, 7'h3c, 16'h0000);
      check(rd, cap_exp(1'b0));
    end
    $display("ident test done");
  endtask : t_ident
  // Line select flips the capability flags; busy flag is not writable
  task automatic t_line;
    acc(1'b1, 7'h66, 16'h0001);
    check(16'(line_selector), 16'h0001);
    acc(1'b0, 7'h3c, 16'h0000);
    check(rd, cap_exp(1'b1));
    acc(1'b1, 7'h66, 16'hfff2);
    check(16'({line_selector, xtal_powerdown}), 16'h0001);
    acc(1'b0, 7'h66, 16'h0000);
    check(rd, 16'h0002);
    acc(1'b0, 7'h3c, 16'h0000);
    check(rd, cap_exp(1'b0));
    acc(1'b1, 7'h66, 16'h0000);
    $display("line test done");
  endtask : t_line
  // Listed rates and both ends of the range; a write answers the old word
  task automatic t_rate;
    logic [15:0] r [5] = '{16'h1f40, 16'h2580, 16'hffff, 16'h0000, 16'hbb80};
    logic [15:0] prev;
    prev = 16'hbb80;
    foreach (r[i]) begin
      acc(1'b1, 7'h40, r[i]);
      check(rd, prev);
      check(sample_rate_value, r[i]);
      acc(1'b0, 7'h40, 16'h0000);
      check(rd, r[i]);
      prev = r[i];
    end
    $display("rate test done");
  endtask : t_rate
  // Link sleep bit writable, other status bits not
  task automatic t_sleep;
    acc(1'b1, 7'h56, 16'hffff);
    check(16'(link_sleep), 16'h0001);
    acc(1'b0, 7'h56, 16'h0000);
    check(rd, 16'h5000);
    acc(1'b1, 7'h56, 16'h0000);
    check(16'(link_sleep), 16'h0000);
    $display("sleep test done");
  endtask : t_sleep
  // Dirty every writable register, then reset them by a capability write
  task automatic t_soft_reset;
    acc(1'b1, 7'h40, 16'h1f40);
    acc(1'b1, 7'h56, 16'h1000);
    acc(1'b1, 7'h66, 16'h0003);
    acc(1'b1, 7'h68, 16'he8b4);
    acc(1'b1, 7'h6a, 16'hff12);
    acc(1'b0, 7'h6a, 16'h0000);
    check(rd, 16'h0012);
    acc(1'b0, 7'h68, 16'h0000);
    check(rd, 16'he8b4);
    acc(1'b1, 7'h3c, 16'ha5a5);
    check(rd, cap_exp(1'b1));
    t_defaults(1'b0);
    $display("soft reset test done");
  endtask : t_soft_reset
  // Main sequence: reset, then the scenarios
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    pins = {1'b1, 2'b11, 4'h0};
    n_errors = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge bit_clk);
    repeat (10) @(posedge clk);
    t_power_on();
    t_defaults(1'b1);
    t_ident();
    t_line();
    t_rate();
    t_sleep();
    t_soft_reset();
    end_of_test();
  end
endmodule : modem_codec_register_map_tb
`default_nettype wire
